// file: verilog/smc_pkg.sv
// shared constants for the sleep mode controller
package smc_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    // register addresses (sleep control printed, mcu control chosen)
    localparam logic [7:0] SLEEP_CTRL_ADDR = 8'h33;
    localparam logic [7:0] MCU_CTRL_ADDR   = 8'h35;
    localparam logic [7:0] STATUS_ADDR     = 8'h36;
    // field positions
    localparam int unsigned ARM_BIT      = 0;
    localparam int unsigned MODE_LSB     = 1;
    localparam int unsigned MODE_MSB     = 3;
    localparam int unsigned BOD_OFF_BIT  = 6;
    localparam int unsigned BOD_EN_BIT   = 5;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // sleep mode codes
    localparam logic [2:0] MODE_IDLE     = 3'h0;
    localparam logic [2:0] MODE_NOISE    = 3'h1;
    localparam logic [2:0] MODE_PDOWN    = 3'h2;
    localparam logic [2:0] MODE_PSAVE    = 3'h3;
    localparam logic [2:0] MODE_STBY     = 3'h6;
    localparam logic [2:0] MODE_XSTBY    = 3'h7;
    // timing
    localparam int unsigned CLK_NS       = 50;
    localparam int unsigned HALT_CYC     = 4;
    localparam int unsigned STBY_CYC     = 6;
    localparam int unsigned BOD_WAKE_US  = 60;
    localparam int unsigned BOD_WAKE_CYC = (BOD_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TIMED_CYC    = 4;
    localparam int unsigned CNT_W        = 16;
    // wake source bit positions
    localparam int unsigned WK_ADC       = 0;
    localparam int unsigned WK_WDT       = 1;
    localparam int unsigned WK_TWI       = 2;
    localparam int unsigned WK_TMR2      = 3;
    localparam int unsigned WK_SPM       = 4;
    localparam int unsigned WK_PCINT     = 5;
    localparam int unsigned WK_OTHER     = 6;
    localparam int unsigned WK_N         = 7;
    typedef enum logic [4:0] {
        SMC_RUN   = 5'h01,
        SMC_SLEEP = 5'h02,
        SMC_START = 5'h04,
        SMC_HALT  = 5'h08,
        SMC_RSTW  = 5'h10
    } smc_state_t;
endpackage

// file: verilog/smc_sleep_ctrl.sv
// sleep mode controller: mode decode, clock gating, wake qualification
//
// Chosen here: the placing of the registers and the plain strobed port.
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int unsigned STARTUP_CYC  = 16,
    parameter int unsigned BOD_WAKE_LEN = BOD_WAKE_CYC
)(
    // clock and reset
    input  wire logic                     CLK_SYS,
    input  wire logic                     NRST,
    // register port
    input  wire logic [smc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [smc_pkg::DATA_W-1:0] WDATA,
    input  wire logic                     WR,
    input  wire logic                     RD,
    output logic      [smc_pkg::DATA_W-1:0] RDATA,
    // core side
    input  wire logic                     SLEEP_INSTR,
    input  wire logic                     SYS_RESET_REQ,
    output logic                          CORE_HALT,
    output logic                          WAKE_TO_VECTOR,
    output logic                          WAKE_IRQ,
    // wake sources
    input  wire logic [smc_pkg::WK_N-1:0] WAKE_SRC,
    input  wire logic                     EXT_IRQ_ZERO,
    input  wire logic                     EXT_IRQ_ONE,
    input  wire logic                     EXT_IRQ_ZERO_LEVEL,
    input  wire logic                     EXT_IRQ_ONE_LEVEL,
    input  wire logic                     ASYNC_TIMER_ASYNC,
    input  wire logic                     CRYSTAL_CLOCK,
    input  wire logic                     CONVERTER_ENABLED,
    // clock domain enables
    output logic                          CORE_CLOCK_EN,
    output logic                          FLASH_CLOCK_EN,
    output logic                          IO_CLOCK_EN,
    output logic                          CONVERTER_CLOCK_EN,
    output logic                          ASYNC_TIMER_CLOCK_EN,
    output logic                          MAIN_OSC_EN,
    output logic                          TIMER_OSC_EN,
    output logic                          BROWNOUT_EN,
    output logic                          CONVERSION_START
);
    import smc_pkg::*;

    smc_state_t             state;
    smc_state_t             next_state;
    logic [3:0]             sleep_ctrl;
    logic                   bod_off;
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       next_cnt;
    logic [2:0]             timed_cnt;
    logic [2:0]             mode_q;
    logic                   bod_was_off;
    logic                   irq_pending;

    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        cyc = CNT_W'(n);
    endfunction

    wire [2:0] mode     = sleep_ctrl[MODE_MSB:MODE_LSB];
    wire       arm      = sleep_ctrl[ARM_BIT];
    wire       wr_sleep = WR && (ADDR == SLEEP_CTRL_ADDR);
    wire       wr_mcu   = WR && (ADDR == MCU_CTRL_ADDR);
    wire       asleep   = (state == SMC_SLEEP);
    wire       m_idle   = (mode_q == MODE_IDLE);
    wire       m_noise  = (mode_q == MODE_NOISE);
    wire       m_pdown  = (mode_q == MODE_PDOWN);
    wire       m_psave  = (mode_q == MODE_PSAVE);
    // standby codes only count with a crystal; otherwise clocks fall back to power-down, and extended standby keeps its timer wake
    wire       m_stby   = (mode_q == MODE_STBY) && CRYSTAL_CLOCK;
    wire       m_xstby  = (mode_q == MODE_XSTBY) && CRYSTAL_CLOCK;
    wire       m_deep   = m_pdown || m_psave || m_stby || m_xstby
                          || (mode_q == MODE_STBY) || (mode_q == MODE_XSTBY);
    wire       asy_ok   = ASYNC_TIMER_ASYNC;

    wire       enter    = (state == SMC_RUN) && SLEEP_INSTR && arm;

    // edge irqs only wake from idle
    wire ext_wake = (EXT_IRQ_ZERO && (m_idle || EXT_IRQ_ZERO_LEVEL))
                  || (EXT_IRQ_ONE && (m_idle || EXT_IRQ_ONE_LEVEL));
    wire wake_idle  = m_idle && (|WAKE_SRC);
    wire wake_noise = m_noise && (WAKE_SRC[WK_ADC] || WAKE_SRC[WK_WDT] || WAKE_SRC[WK_TWI]
                      || (WAKE_SRC[WK_TMR2] && asy_ok) || WAKE_SRC[WK_SPM]
                      || WAKE_SRC[WK_PCINT]);
    wire wake_deep  = m_deep && (WAKE_SRC[WK_WDT] || WAKE_SRC[WK_TWI] || WAKE_SRC[WK_PCINT]);
    wire wake_tmr   = (m_psave || (mode_q == MODE_XSTBY)) && WAKE_SRC[WK_TMR2] && asy_ok;
    wire wake_any   = ext_wake || wake_idle || wake_noise || wake_deep || wake_tmr;

    wire bod_eligible = m_deep;

    wire [CNT_W-1:0] start_len =
        (m_stby || m_xstby) ? cyc(STBY_CYC) :
        (m_deep)            ? cyc(STARTUP_CYC) :
                              cyc(1);
    wire [CNT_W-1:0] wake_len =
        (bod_was_off && (start_len < cyc(BOD_WAKE_LEN))) ? cyc(BOD_WAKE_LEN) : start_len;

    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - cyc(1) : cnt;
        unique case (state)
            SMC_RUN:
                if (enter)
                begin
                    next_state = SMC_SLEEP;
                end
            SMC_SLEEP:
                if (SYS_RESET_REQ)
                begin
                    next_state = SMC_RSTW;
                    next_cnt   = wake_len;
                end
                else if (wake_any)
                begin
                    next_state = SMC_START;
                    next_cnt   = wake_len;
                end
            SMC_START:
                if (cnt == cyc(1))
                begin
                    next_state = SMC_HALT;
                    next_cnt   = cyc(HALT_CYC);
                end
            SMC_HALT:
                if (cnt == cyc(1))
                begin
                    next_state = SMC_RUN;
                end
            SMC_RSTW:
                if (cnt == cyc(1))
                begin
                    next_state = SMC_RUN;
                end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            state <= SMC_RUN;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            sleep_ctrl <= REG_RESET[3:0];
        end
        else if (wr_sleep)
        begin
            sleep_ctrl <= WDATA[MODE_MSB:ARM_BIT];
        end
    end

    // enable bit opens a short window for the detector bit
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            timed_cnt <= '0;
        end
        else if (wr_mcu && WDATA[BOD_EN_BIT] && !WDATA[BOD_OFF_BIT])
        begin
            timed_cnt <= 3'(TIMED_CYC);
        end
        else if (timed_cnt != '0)
        begin
            timed_cnt <= timed_cnt - 3'h1;
        end
    end
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            bod_off <= 1'b0;
        end
        else if (wr_mcu && (timed_cnt != '0))
        begin
            bod_off <= WDATA[BOD_OFF_BIT];
        end
    end
    // mode latched at entry so a later write cannot change a running sleep
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            mode_q      <= MODE_IDLE;
            bod_was_off <= 1'b0;
        end
        else if (enter)
        begin
            mode_q      <= mode;
            bod_was_off <= 1'b0;
        end
        else if (asleep && bod_off && bod_eligible)
        begin
            bod_was_off <= 1'b1;
        end
    end
    // interrupt wake marker, cleared when core resumes
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            irq_pending <= 1'b0;
        end
        else if (asleep && !SYS_RESET_REQ && wake_any)
        begin
            irq_pending <= 1'b1;
        end
        else if (state == SMC_RUN)
        begin
            irq_pending <= 1'b0;
        end
    end
    // no memory write path exists; core just stays halted
    wire stopped = asleep || (state == SMC_START);
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            CORE_CLOCK_EN        <= 1'b1;
            FLASH_CLOCK_EN       <= 1'b1;
            IO_CLOCK_EN          <= 1'b1;
            CONVERTER_CLOCK_EN   <= 1'b1;
            ASYNC_TIMER_CLOCK_EN <= 1'b1;
            MAIN_OSC_EN          <= 1'b1;
            TIMER_OSC_EN         <= 1'b1;
            BROWNOUT_EN          <= 1'b1;
        end
        else
        begin
            CORE_CLOCK_EN        <= (next_state == SMC_RUN);
            FLASH_CLOCK_EN       <= (next_state == SMC_RUN);
            IO_CLOCK_EN          <= !(stopped && !m_idle);
            CONVERTER_CLOCK_EN   <= !(stopped && !m_idle && !m_noise);
            ASYNC_TIMER_CLOCK_EN <= !stopped || m_idle
                                    || ((m_noise || m_psave || m_xstby) && asy_ok);
            MAIN_OSC_EN          <= !stopped || m_idle || m_noise || m_stby || m_xstby;
            TIMER_OSC_EN         <= !stopped || ((m_idle || m_noise || m_psave || m_xstby)
                                    && asy_ok);
            BROWNOUT_EN          <= !(asleep && (next_state == SMC_SLEEP)
                                    && bod_off && bod_eligible);
        end
    end

    wire [DATA_W-1:0] rd_word =
        !RD                       ? '0 :
        (ADDR == SLEEP_CTRL_ADDR) ? {4'h0, sleep_ctrl} :
        (ADDR == MCU_CTRL_ADDR)   ? (8'h01 << BOD_OFF_BIT) & {8{bod_off}} :
        (ADDR == STATUS_ADDR)     ? {3'h0, state} :
                                    '0;
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            CONVERSION_START <= 1'b0;
            WAKE_IRQ         <= 1'b0;
            WAKE_TO_VECTOR   <= 1'b0;
            RDATA            <= '0;
        end
        else
        begin
            CONVERSION_START <= enter && CONVERTER_ENABLED
                                && ((mode == MODE_IDLE) || (mode == MODE_NOISE));
            WAKE_IRQ         <= (state == SMC_HALT) && (next_state == SMC_RUN) && irq_pending;
            WAKE_TO_VECTOR   <= (state == SMC_RSTW) && (next_state == SMC_RUN);
            RDATA            <= rd_word;
        end
    end

    assign CORE_HALT = (state != SMC_RUN);

    sequence halt_run_s;
        (state == SMC_HALT) [*4] ##1 (state == SMC_RUN);
    endsequence
    halt_four_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        $rose(state == SMC_HALT) |-> halt_run_s)
        else $error("halt not four cycles");
    arm_needed_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state == SMC_RUN && SLEEP_INSTR && !arm) |=> state == SMC_RUN)
        else $error("slept without arm bit");
    idle_clocks_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (asleep && m_idle && $past(asleep)) |-> !CORE_CLOCK_EN && IO_CLOCK_EN)
        else $error("idle clock gating wrong");
    noise_io_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (asleep && m_noise && $past(asleep)) |-> !IO_CLOCK_EN && CONVERTER_CLOCK_EN)
        else $error("noise clock gating wrong");
    pdown_osc_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (asleep && m_pdown && $past(asleep)) |-> !MAIN_OSC_EN && !CONVERTER_CLOCK_EN)
        else $error("power-down clocks running");
    edge_nowake_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (asleep && m_pdown && WAKE_SRC == '0 && !SYS_RESET_REQ
         && !EXT_IRQ_ZERO_LEVEL && !EXT_IRQ_ONE_LEVEL) |=> asleep)
        else $error("edge irq woke deep sleep");
    reset_vec_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (asleep && SYS_RESET_REQ) |=> state == SMC_RSTW)
        else $error("reset wake missing");
    // the wake counter bounds the reset wake; a delay range would be far too long
    rstw_len_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state == SMC_RSTW) |-> (cnt != '0) && (cnt <= cyc(STARTUP_CYC + STBY_CYC + BOD_WAKE_LEN)))
        else $error("reset wake too long");
    vec_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state == SMC_RSTW && cnt == cyc(1)) |=> WAKE_TO_VECTOR)
        else $error("vector restart missing");
    bod_back_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (state == SMC_HALT) |-> BROWNOUT_EN)
        else $error("detector not back on");
    bod_scope_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (m_idle || m_noise) |-> BROWNOUT_EN)
        else $error("detector off in shallow mode");
    ro_bits_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        $past(RD && ADDR == SLEEP_CTRL_ADDR) |-> RDATA[7:4] == 4'h0)
        else $error("reserved bits nonzero");
endmodule

// file: tb/smc_core_model.sv
// core and wake source model facing the sleep controller
module smc_core_model (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // requests from the bench
    input  wire logic                     sleep_req,
    input  wire logic [smc_pkg::WK_N-1:0] wake_req,
    // controller answers
    input  wire logic                     wake_irq,
    input  wire logic                     wake_vec,
    // towards the controller
    output logic                          sleep_instr,
    output logic      [smc_pkg::WK_N-1:0] wake_src
);
    timeunit 1ns;
    timeprecision 1ns;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_instr <= 1'b0;
            wake_src    <= 7'h00;
        end
        else
        begin
            sleep_instr <= sleep_req & ~sleep_instr;
            // source held until the wake is seen, then acknowledged
            wake_src    <= (wake_irq | wake_vec) ? 7'h00 : wake_req;
        end
    end
endmodule

// file: tb/tb_sleep_mode_controller.sv
// self-checking bench for the sleep mode controller
module tb_sleep_mode_controller;
    timeunit 1ns;
    timeprecision 1ns;
    import smc_pkg::*;
    // short start-up so each wake stays a few cycles long
    localparam int STARTUP = 4;
    localparam int BODLEN  = 8;
    logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rst_req = 1'b0;
    logic       sleep_req = 1'b0, sleep_instr, halt, wk_vec, wk_irq, brown_en, conv_start;
    logic       irq0 = 1'b0, irq0_lvl = 1'b0, tmr_async = 1'b1, conv_on = 1'b1;
    logic       irq1 = 1'b0, irq1_lvl = 1'b0, xtal = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [6:0] wake_req = 7'h00, wake_src, en;
    int         err_total = 0, total_checks = 0, conv_cnt = 0;

    smc_sleep_ctrl #(.STARTUP_CYC(STARTUP), .BOD_WAKE_LEN(BODLEN)) dut (
        .CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SLEEP_INSTR(sleep_instr), .SYS_RESET_REQ(rst_req),
        .CORE_HALT(halt), .WAKE_TO_VECTOR(wk_vec), .WAKE_IRQ(wk_irq), .WAKE_SRC(wake_src),
        .EXT_IRQ_ZERO(irq0), .EXT_IRQ_ONE(irq1), .EXT_IRQ_ZERO_LEVEL(irq0_lvl),
        .EXT_IRQ_ONE_LEVEL(irq1_lvl), .ASYNC_TIMER_ASYNC(tmr_async),
        .CRYSTAL_CLOCK(xtal),
        .CONVERTER_ENABLED(conv_on), .CORE_CLOCK_EN(en[6]), .FLASH_CLOCK_EN(en[5]),
        .IO_CLOCK_EN(en[4]), .CONVERTER_CLOCK_EN(en[3]), .ASYNC_TIMER_CLOCK_EN(en[2]),
        .MAIN_OSC_EN(en[1]), .TIMER_OSC_EN(en[0]), .BROWNOUT_EN(brown_en),
        .CONVERSION_START(conv_start));

    smc_core_model core (.clk(clk), .nrst(nrst), .sleep_req(sleep_req), .wake_req(wake_req),
        .wake_irq(wk_irq), .wake_vec(wk_vec), .sleep_instr(sleep_instr), .wake_src(wake_src));

    always #25 clk = ~clk;

    always @(posedge clk)
        if (conv_start === 1'b1) conv_cnt++;

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic go(input logic [2:0] m);
        reg_wr(SLEEP_CTRL_ADDR, {4'h0, m, 1'b1});
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (4) @(negedge clk);
        chk("halt", 16'h1, {15'h0, halt});
    endtask

    // an empty source vector means the level external irq does the waking
    task automatic wk(input logic [6:0] src, input int lo);
        int n;
        n = 0;
        @(posedge clk);
        wake_req <= src;
        if (src == 7'h00)
        begin
            irq0_lvl <= 1'b1;
            irq1_lvl <= 1'b1;
        end
        @(negedge clk);
        while (wk_irq !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk("wake delay", 16'(lo), (n >= lo && n <= lo + 3) ? 16'(lo) : 16'(n));
        @(posedge clk);
        wake_req <= 7'h00;
        irq0     <= 1'b0;
        irq0_lvl <= 1'b0;
        irq1     <= 1'b0;
        irq1_lvl <= 1'b0;
    endtask

    task automatic nowake(input logic [6:0] src);
        logic hit;
        hit = 1'b0;
        @(posedge clk);
        wake_req <= src;
        repeat (30)
        begin
            @(negedge clk);
            if (wk_irq === 1'b1 || halt !== 1'b1) hit = 1'b1;
        end
        chk("no wake", 16'h0, {15'h0, hit});
        @(posedge clk);
        wake_req <= 7'h00;
    endtask

    task automatic rwake;
        int n;
        n = 0;
        @(posedge clk);
        rst_req <= 1'b1;
        @(negedge clk);
        while (wk_vec !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk("vector wake", 16'h1, {15'h0, wk_vec});
        @(posedge clk);
        rst_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk("clocks back", 16'hFF, {8'h0, brown_en, en});
    endtask

    task automatic t_regs;
        reg_rd(SLEEP_CTRL_ADDR, 8'h00, "sleep ctrl reset");
        reg_rd(MCU_CTRL_ADDR, 8'h00, "mcu ctrl reset");
        reg_wr(SLEEP_CTRL_ADDR, 8'hFF);
        reg_rd(SLEEP_CTRL_ADDR, 8'h0F, "sleep ctrl fields");
        reg_wr(MCU_CTRL_ADDR, 8'h40);
        reg_rd(MCU_CTRL_ADDR, 8'h00, "unguarded bit");
        reg_rd(8'h10, 8'h00, "unmapped");
        reg_wr(SLEEP_CTRL_ADDR, {4'h0, MODE_PDOWN, 1'b0});
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (4) @(negedge clk);
        chk("unarmed halt", 16'h0, {15'h0, halt});
        chk("unarmed clocks", 16'h7F, {9'h0, en});
        $display("test registers done");
    endtask

    task automatic t_modes;
        logic [2:0] code [6] = '{MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_PSAVE,
                                 MODE_STBY, MODE_XSTBY};
        logic [6:0] exp [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
        int c0;
        for (int i = 0; i < 6; i++)
        begin
            c0 = conv_cnt;
            go(code[i]);
            chk("domain clocks", {9'h0, exp[i]}, {9'h0, en});
            chk("conversion start", (i < 2) ? 16'h1 : 16'h0, 16'(conv_cnt - c0));
            rwake();
        end
        $display("test modes done");
    endtask

    task automatic t_wake;
        int c0;
        @(posedge clk);
        tmr_async <= 1'b0;
        go(MODE_NOISE);
        chk("noise clocks", 16'h0A, {9'h0, en});
        nowake(7'h48);
        wk(7'h01, 6);
        tmr_async <= 1'b1;
        go(MODE_PDOWN);
        @(posedge clk);
        irq0 <= 1'b1;
        nowake(7'h01);
        wk(7'h00, STARTUP + 4);
        conv_on <= 1'b0;
        c0 = conv_cnt;
        go(MODE_IDLE);
        chk("conversion off", 16'h0, 16'(conv_cnt - c0));
        wk(7'h40, 6);
        go(MODE_STBY);
        wk(7'h02, 11);
        @(posedge clk);
        xtal <= 1'b0;
        go(MODE_STBY);
        chk("standby no crystal", 16'h00, {9'h0, en});
        rwake();
        @(posedge clk);
        xtal <= 1'b1;
        $display("test wake done");
    endtask

    task automatic t_bod;
        reg_wr(MCU_CTRL_ADDR, 8'h20);
        reg_wr(MCU_CTRL_ADDR, 8'h40);
        reg_rd(MCU_CTRL_ADDR, 8'h40, "timed bit");
        go(MODE_IDLE);
        chk("detector idle", 16'h1, {15'h0, brown_en});
        rwake();
        go(MODE_PDOWN);
        chk("detector off", 16'h0, {15'h0, brown_en});
        @(posedge clk);
        irq1 <= 1'b1;
        wk(7'h00, BODLEN + 4);
        repeat (2) @(negedge clk);
        chk("detector back", 16'h1, {15'h0, brown_en});
        $display("test detector done");
    endtask

    // a hang anywhere ends the run as a failure
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_modes();
        t_wake();
        t_bod();
        stop_test();
    end
endmodule
